// [logic/pcia_top.sv]
// indirect access controller for the per-channel control memory
// assumes one master on the register port and a channel counter input
module pcia_top (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire logic [5:0] channelSel,
    output logic [7:0] channelCtrl,
    output logic channelCtrlValid
);

    pcia_mem_if memBus ();

    pcia_ctrl_mem u_mem (
        .sys_clk(sys_clk),
        .bus(memBus)
    );

    // --------------------------------------------------------------
    // register state
    // --------------------------------------------------------------
    logic indirectSelect_r, indirectSelect_nxt;
    logic streamEnable_r, streamEnable_nxt;
    logic readNotWrite_r, readNotWrite_nxt;
    logic [5:0] locAddr_r, locAddr_nxt;
    logic [7:0] dataBuf_r, dataBuf_nxt;
    logic [7:0] regRdData_r, regRdData_nxt;
    logic [7:0] channelCtrl_r, channelCtrl_nxt;
    logic channelValid_r, channelValid_nxt;
    logic streamEnableD_r, streamEnableD_nxt;
    pcia_pkg::pcia_state_t state_r, state_nxt;

    // --------------------------------------------------------------
    // register decode
    // --------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    logic cfgWrite;
    logic bufWrite;
    logic reqWrite;
    logic busy;

    // write strobes per register, unmapped offsets fall through
    assign cfgWrite = regWr && hit(regAddr, pcia_pkg::OFS_CONFIG);
    assign bufWrite = regWr && hit(regAddr, pcia_pkg::OFS_DATA_BUF);
    assign reqWrite = regWr && hit(regAddr, pcia_pkg::OFS_ADDR_CTRL);
    assign busy = (state_r != pcia_pkg::PCIA_IDLE);

    // --------------------------------------------------------------
    // configuration
    // --------------------------------------------------------------
    always_comb begin
        indirectSelect_nxt = indirectSelect_r;
        streamEnable_nxt = streamEnable_r;
        if (cfgWrite) begin
            indirectSelect_nxt = regWrData[pcia_pkg::BIT_INDIRECT_SELECT];
            streamEnable_nxt = regWrData[pcia_pkg::BIT_CTRL_STREAM_EN];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            // direct mode and streams off
            indirectSelect_r <=
                pcia_pkg::CONFIG_RST[pcia_pkg::BIT_INDIRECT_SELECT];
            streamEnable_r <=
                pcia_pkg::CONFIG_RST[pcia_pkg::BIT_CTRL_STREAM_EN];
        end else begin
            indirectSelect_r <= indirectSelect_nxt;
            streamEnable_r <= streamEnable_nxt;
        end
    end

    // --------------------------------------------------------------
    // indirect request engine
    // --------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        readNotWrite_nxt = readNotWrite_r;
        locAddr_nxt = locAddr_r;
        dataBuf_nxt = dataBuf_r;
        // buffer is host-writable only while idle
        if (bufWrite && !busy) begin
            dataBuf_nxt = regWrData;
        end
        case (state_r)
            pcia_pkg::PCIA_IDLE: begin
                // request taken only in indirect mode
                if (reqWrite && indirectSelect_r) begin
                    readNotWrite_nxt =
                        regWrData[pcia_pkg::BIT_READ_NOT_WRITE];
                    locAddr_nxt = regWrData[pcia_pkg::LOC_W-1:0];
                    state_nxt = pcia_pkg::PCIA_ACCESS;
                end
            end
            pcia_pkg::PCIA_ACCESS: begin
                // memory read data lands next cycle
                state_nxt = pcia_pkg::PCIA_DONE;
            end
            pcia_pkg::PCIA_DONE: begin
                if (readNotWrite_r) begin
                    dataBuf_nxt = memBus.readDataA;
                end
                state_nxt = pcia_pkg::PCIA_IDLE;
            end
            default: begin
                state_nxt = pcia_pkg::PCIA_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_r <= pcia_pkg::PCIA_IDLE;
            readNotWrite_r <= 1'b0;
            locAddr_r <= '0;
            dataBuf_r <= pcia_pkg::DATA_RST;
        end else begin
            state_r <= state_nxt;
            readNotWrite_r <= readNotWrite_nxt;
            locAddr_r <= locAddr_nxt;
            dataBuf_r <= dataBuf_nxt;
        end
    end

    // --------------------------------------------------------------
    // register read port
    // --------------------------------------------------------------
    always_comb begin
        // zero outside the read slot and for unmapped offsets
        regRdData_nxt = pcia_pkg::READ_ZERO;
        if (regRd) begin
            if (hit(regAddr, pcia_pkg::OFS_CONFIG)) begin
                regRdData_nxt[pcia_pkg::BIT_INDIRECT_SELECT] =
                    indirectSelect_r;
                regRdData_nxt[pcia_pkg::BIT_CTRL_STREAM_EN] = streamEnable_r;
            end else if (hit(regAddr, pcia_pkg::OFS_STATUS)) begin
                regRdData_nxt[pcia_pkg::BIT_BUSY] = busy;
            end else if (hit(regAddr, pcia_pkg::OFS_ADDR_CTRL)) begin
                regRdData_nxt[pcia_pkg::BIT_READ_NOT_WRITE] = readNotWrite_r;
                regRdData_nxt[pcia_pkg::LOC_W-1:0] = locAddr_r;
            end else if (hit(regAddr, pcia_pkg::OFS_DATA_BUF)) begin
                regRdData_nxt = dataBuf_r;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            regRdData_r <= pcia_pkg::READ_ZERO;
        end else begin
            regRdData_r <= regRdData_nxt;
        end
    end

    // --------------------------------------------------------------
    // per-channel control stream
    // --------------------------------------------------------------
    always_comb begin
        // enable delayed to match the registered memory read
        // streams gated by enable
        streamEnableD_nxt = streamEnable_r;
        channelValid_nxt = streamEnableD_r;
        channelCtrl_nxt = streamEnableD_r ? memBus.readDataB
                                          : pcia_pkg::DATA_RST;
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            streamEnableD_r <= 1'b0;
            channelValid_r <= 1'b0;
            channelCtrl_r <= pcia_pkg::DATA_RST;
        end else begin
            streamEnableD_r <= streamEnableD_nxt;
            channelValid_r <= channelValid_nxt;
            channelCtrl_r <= channelCtrl_nxt;
        end
    end

    // --------------------------------------------------------------
    // memory ports
    // --------------------------------------------------------------
    always_comb begin
        // store on the access cycle of a write
        memBus.writeEn = (state_r == pcia_pkg::PCIA_ACCESS)
                         && !readNotWrite_r;
        memBus.writeAddr = locAddr_r;
        memBus.writeData = dataBuf_r;
        // port a serves the host, port b the channel stream
        memBus.readAddrA = locAddr_r;
        memBus.readAddrB = channelSel;
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign regRdData = regRdData_r;
    assign channelCtrl = channelCtrl_r;
    assign channelCtrlValid = channelValid_r;

endmodule

// [logic/pcia_pkg.sv]
// package of constants for the per-channel control indirect access block
// assumes a plain register port with 8-bit addresses and 8-bit data
package pcia_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int LOC_W = 6;
    localparam int LOC_N = 64;

    // register offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h01;
    localparam logic [7:0] OFS_ADDR_CTRL = 8'h02;
    localparam logic [7:0] OFS_DATA_BUF = 8'h03;

    // field positions
    localparam int BIT_INDIRECT_SELECT = 0;
    localparam int BIT_CTRL_STREAM_EN = 1;
    localparam int BIT_BUSY = 0;
    localparam int BIT_READ_NOT_WRITE = 7;

    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    typedef enum logic [1:0] {
        PCIA_IDLE = 2'b00,
        PCIA_ACCESS = 2'b01,
        PCIA_DONE = 2'b11
    } pcia_state_t;

endpackage

// [logic/pcia_mem_if.sv]
// interface between the access controller and its control memory
// assumes one clock shared by both ends
interface pcia_mem_if;
    logic writeEn;
    logic [5:0] writeAddr;
    logic [7:0] writeData;
    logic [5:0] readAddrA;
    logic [7:0] readDataA;
    logic [5:0] readAddrB;
    logic [7:0] readDataB;

    modport ctrl (
        output writeEn,
        output writeAddr,
        output writeData,
        output readAddrA,
        input readDataA,
        output readAddrB,
        input readDataB
    );
    modport mem (
        input writeEn,
        input writeAddr,
        input writeData,
        input readAddrA,
        output readDataA,
        input readAddrB,
        output readDataB
    );
endinterface

// [logic/pcia_ctrl_mem.sv]
// 64 by 8 control memory, one write port and two registered read ports
// assumes sys_clk; contents are not reset
module pcia_ctrl_mem (
    input wire logic sys_clk,
    pcia_mem_if.mem bus
);

    logic [7:0] mem [0:63];
    logic [7:0] readA_r;
    logic [7:0] readB_r;

    always_ff @(posedge sys_clk) begin
        if (bus.writeEn) begin
            mem[bus.writeAddr] <= bus.writeData;
        end
        readA_r <= mem[bus.readAddrA];
        readB_r <= mem[bus.readAddrB];
    end

    assign bus.readDataA = readA_r;
    assign bus.readDataB = readB_r;

endmodule

// [verification/pcia_chk.sv]
// port checker for the indirect access block
// assumes it is bound into pcia_top
module pcia_chk (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdData,
    input wire logic [5:0] channelSel,
    input wire logic [7:0] channelCtrl,
    input wire logic channelCtrlValid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cfgR;
    logic [1:0] bCnt;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // shadow of config and busy span
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cfgR <= 2'h0;
            bCnt <= 2'h0;
        end else begin
            if (regWr && regAddr == 8'h00)
                cfgR <= regWrData[1:0];
            if (bCnt != 2'h0)
                bCnt <= bCnt - 2'h1;
            else if (regWr && regAddr == 8'h02 && cfgR[0])
                bCnt <= 2'h2;
        end
    end
    chk_gate_off: assert property (
        !channelCtrlValid |-> channelCtrl == 8'h00)
        else $error("stream output while disabled");
    chk_valid_lag: assert property (
        $past(nrst, 2) |-> channelCtrlValid == $past(cfgR[1], 2))
        else $error("stream valid does not follow enable");
    chk_valid_rise: assert property (
        $rose(channelCtrlValid)
        |-> $past(regWr && regAddr == 8'h00 && regWrData[1], 3))
        else $error("stream valid rose without enable write");
    chk_valid_fall: assert property (
        $fell(channelCtrlValid)
        |-> $past(regWr && regAddr == 8'h00 && !regWrData[1], 3))
        else $error("stream valid fell without disable write");
    chk_rd_idle: assert property (
        !$past(regRd) |-> regRdData == 8'h00)
        else $error("read data outside read slot");
    chk_rd_unmap: assert property (
        $past(regRd && regAddr > 8'h03) |-> regRdData == 8'h00)
        else $error("unmapped read not zero");
    chk_busy_flag: assert property (
        $past(regRd && regAddr == 8'h01)
        |-> regRdData[0] == $past(bCnt != 2'h0))
        else $error("busy flag wrong");
    chk_cfg_read: assert property (
        $past(regRd && regAddr == 8'h00)
        |-> regRdData[1:0] == $past(cfgR))
        else $error("config readback wrong");
endmodule

bind pcia_top pcia_chk u_pcia_chk (.sys_clk, .nrst, .regAddr, .regWrData,
    .regWr, .regRd, .regRdData, .channelSel, .channelCtrl, .channelCtrlValid);

// [verification/tb.sv]
// self-checking bench for the indirect access block
// assumes pcia_top with its checker bound beside it
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [5:0] channelSel = 6'h00;
    logic [7:0] regRdData, channelCtrl, d, s;
    logic channelCtrlValid;
    logic [7:0] mem [64];
    int nErrors = 0;
    int nTests = 0;
    pcia_top u_pcia_top (.sys_clk, .nrst, .regAddr, .regWrData, .regWr,
        .regRd, .regRdData, .channelSel, .channelCtrl, .channelCtrlValid);
    initial forever #10 sys_clk = ~sys_clk;
    task conclude;
        $display("tests %0d errors %0d", nTests, nErrors);
        if (nErrors == 0 && nTests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        nTests++;
        if (got !== exp) begin
            nErrors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        @(negedge sys_clk);
        v = regRdData;
    endtask
    function automatic logic [7:0] ac(input logic rnw, input logic [5:0] l);
        return {rnw, 1'b0, l};
    endfunction
    function automatic logic [7:0] ctrlExp(input logic en,
                                           input logic [5:0] l);
        return en ? mem[l] : 8'h00;
    endfunction
    // post one request, expect busy at once, then poll it down
    task access(input logic rnw, input logic [5:0] l);
        wr(8'h02, ac(rnw, l));
        rd(8'h01, s);
        chk(s & 8'h01, 8'h01);
        repeat (8) if (s[0]) rd(8'h01, s);
        chk(s & 8'h01, 8'h00);
    endtask
    initial begin
        void'($urandom(32'hd5f9));
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(8'h00, d);
        chk(d, 8'h00);
        wr(8'h02, ac(1'b0, 6'h01));
        rd(8'h01, d);
        chk(d & 8'h01, 8'h00);
        $display("test reset done");
        wr(8'h00, 8'h01);
        for (int i = 0; i < 64; i++) begin
            mem[i] = (i == 63) ? 8'hff : 8'($urandom);
            wr(8'h03, mem[i]);
            access(1'b0, 6'(i));
        end
        $display("test fill done");
        for (int i = 63; i >= 0; i--) begin
            access(1'b1, 6'(i));
            rd(8'h03, d);
            chk(d, mem[i]);
            rd(8'h02, d);
            chk(d, ac(1'b1, 6'(i)));
        end
        // buffer write while busy must be refused
        wr(8'h02, ac(1'b0, 6'h00));
        wr(8'h03, ~mem[0]);
        rd(8'h03, d);
        chk(d, mem[0]);
        $display("test read done");
        for (int e = 0; e < 2; e++) begin
            wr(8'h00, {6'h00, 1'(e), 1'b1});
            for (int k = 0; k < 16; k++) begin
                @(posedge sys_clk);
                channelSel <= (k == 0) ? 6'h3f : 6'($urandom);
                repeat (3) @(posedge sys_clk);
                @(negedge sys_clk);
                chk(channelCtrl, ctrlExp(e[0], channelSel));
                chk({7'h00, channelCtrlValid}, {7'h00, e[0]});
            end
        end
        $display("test stream done");
        rd(8'h05, d);
        chk(d, 8'h00);
        conclude();
    end
    initial begin
        repeat (50000) @(posedge sys_clk);
        nErrors++;
        conclude();
    end
endmodule
